// *** logic/ncos_pkg.sv ***
package ncos_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ        = 100000000;       // System clock rate
   localparam int unsigned PWRUP_HOLD_MS = 4000;            // Power-up reset hold
   localparam int unsigned RRW_HOLD_MS   = 500;             // Hold after rewind release
   localparam int unsigned STOP_HOLD_MS  = 1000;            // Hold after stop or alarm
   localparam int unsigned PWRUP_CYC     = PWRUP_HOLD_MS * (CLK_HZ / 1000);
   localparam int unsigned RRW_CYC       = RRW_HOLD_MS * (CLK_HZ / 1000);
   localparam int unsigned STOP_CYC      = STOP_HOLD_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W         = 29;              // Holds the longest count
   // ----------------------------------------
   // Register map and fields
   // ----------------------------------------
   localparam logic [3:0] REG_STATUS  = 4'h0;               // Read-only flags
   localparam logic [3:0] REG_COMMAND = 4'h4;               // Sequence commands
   localparam int unsigned CMD_START   = 0;                 // Write 1: start pulse
   localparam int unsigned CMD_PAUSE_N = 1;                 // Pause command, low active
   localparam int unsigned CMD_RRW     = 2;                 // Reset and rewind level
   localparam int unsigned CMD_STROBE  = 3;                 // Random feed strobe
   localparam int unsigned CMD_MODE    = 4;                 // Mode request, 3 bits
   localparam int unsigned ST_MODE     = 12;                // Active mode in status
   localparam int unsigned ST_SVOFF    = 16;                // Axis servo-off readback
   localparam logic [7:0] CMD_RST_VAL  = 8'h02;             // Pause released, memory mode
   // ----------------------------------------
   // Operating modes
   // ----------------------------------------
   localparam logic [2:0] MODE_MEM  = 3'h0;
   localparam logic [2:0] MODE_MDI  = 3'h1;
   localparam logic [2:0] MODE_TAPE = 3'h2;
   localparam logic [2:0] MODE_JOG  = 3'h3;
   localparam logic [2:0] MODE_HND  = 3'h4;
   localparam logic [2:0] MODE_INC  = 3'h5;
   localparam logic [2:0] MODE_REF  = 3'h6;
   localparam logic [2:0] MODE_MRF  = 3'h7;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   localparam int unsigned NAXES = 4;
   typedef enum logic [1:0] {ST_RESET, ST_STOPPED, ST_PAUSED, ST_EXEC} ncos_auto_t;
   typedef struct packed {
      logic [NAXES-1:0] axis_servo_off_n;   // Per-axis servo off, low active
      logic [NAXES-1:0] axis_is_plc;        // Axis driven by the sequence program
      logic [NAXES-1:0] axis_accdec_busy;   // Axis has acc/dec delay left
      logic             feed_done;          // Random feed motion complete
      logic             block_stop;         // Halted at end of a block
      logic             servo_alarm_reset;  // Resettable alarm cleared
      logic             servo_diag_ok;      // Servo self-diagnosis passed
      logic             power_fail;         // Controller power going down
      logic             cpu_fault;          // Processor or memory fault
      logic             servo_alarm_fatal;  // Alarm needing power cycle
      logic             servo_alarm;        // Any servo alarm
      logic             estop;              // Emergency stop input
   } ncos_pin_t;
   localparam int unsigned PIN_W = $bits(ncos_pin_t);
   typedef struct packed {
      logic all_axes_smoothing_zero;
      logic mdi_mode_flag;
      logic manual_random_feed_active;
      logic in_reset_flag;
      logic auto_paused_flag;
      logic auto_executing_flag;
      logic auto_run_flag;
      logic servo_ready;
      logic controller_ready;
   } ncos_flags_t;
endpackage : ncos_pkg

// *** logic/ncos_status.sv ***
`timescale 1ns/100ps
module ncos_status
   import ncos_pkg::*;
#(
   parameter int unsigned PWRUP_CYC_P = PWRUP_CYC,   // Power-up hold in cycles
   parameter int unsigned RRW_CYC_P   = RRW_CYC,     // Rewind hold in cycles
   parameter int unsigned STOP_CYC_P  = STOP_CYC     // Stop/alarm hold in cycles
)(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire ncos_pin_t   pins,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output ncos_flags_t      flags
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [PIN_W-1:0] s1_q;         // First stage, read by s2 only
   logic [PIN_W-1:0] s2_q;         // Second stage
   logic [PIN_W-1:0] s3_q;         // Third stage
   logic [PIN_W-1:0] filt_q;       // Accepted level
   logic [PIN_W-1:0] pin_raw;      // Flattened pin group
   ncos_pin_t        pin_f;        // Filtered pins as a struct

   assign pin_raw = pins;

   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++)
      begin : g_sync
         // Level changes only once stages two and three agree
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               s1_q[gi]   <= 1'b0;
               s2_q[gi]   <= 1'b0;
               s3_q[gi]   <= 1'b0;
               filt_q[gi] <= 1'b0;
            end
            else
            begin
               s1_q[gi] <= pin_raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi])
               begin
                  filt_q[gi] <= s3_q[gi];
               end
            end
         end
      end
   endgenerate

   assign pin_f = ncos_pin_t'(filt_q);

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic        wait_q;          // Registered waitrequest
   logic        wait_d;
   logic [31:0] rdata_q;         // Registered read data
   logic [31:0] rdata_d;
   logic [7:0]  cmd_q;           // Command register, byte 0
   logic [7:0]  cmd_d;
   logic        start_q;         // One-cycle start pulse
   logic        start_d;
   logic        req;             // Any access pending
   logic        commit;          // Edge where master sees wait low
   logic        hit_cmd;         // Command register addressed
   logic        hit_st;          // Status register addressed
   logic        wr_cmd;          // Committed byte-0 command write
   logic [31:0] status_word;     // Assembled status read value

   assign req     = avs_read | avs_write;
   assign commit  = req & ~wait_q;
   assign hit_cmd = (avs_address == REG_COMMAND);
   assign hit_st  = (avs_address == REG_STATUS);
   assign wr_cmd  = commit & avs_write & hit_cmd & avs_byteenable[0];

   // One wait cycle: wait drops after the first request cycle
   assign wait_d = ~(req & wait_q);

   // Start bit is self-clearing and never stored
   assign start_d = wr_cmd & avs_writedata[CMD_START];
   assign cmd_d   = wr_cmd ? {avs_writedata[7:1], 1'b0} : cmd_q;

   // Unmapped addresses read zero and ignore writes
   assign rdata_d = (req & wait_q & avs_read) ?
                    (hit_st ? status_word : (hit_cmd ? {24'h000000, cmd_q} : 32'h00000000)) :
                    rdata_q;

   // Bus registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h00000000;
         cmd_q   <= CMD_RST_VAL;
         start_q <= 1'b0;
      end
      else
      begin
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
         cmd_q   <= cmd_d;
         start_q <= start_d;
      end
   end

   assign avs_waitrequest = wait_q;
   assign avs_readdata    = rdata_q;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   logic       pause_n;          // Pause command, low active
   logic       reset_rewind_cmd;              // Reset and rewind level
   logic       strobe;           // Random feed strobe level
   logic [2:0] mode_req;         // Requested mode
   logic       strobe_prev_q;    // Strobe one cycle back

   assign pause_n  = cmd_q[CMD_PAUSE_N];
   assign reset_rewind_cmd      = cmd_q[CMD_RRW];
   assign strobe   = cmd_q[CMD_STROBE];
   assign mode_req = cmd_q[CMD_MODE +: 3];

   // Automatic modes are memory, MDI and tape
   function automatic logic is_auto(input logic [2:0] m);
      is_auto = (m == MODE_MEM) | (m == MODE_MDI) | (m == MODE_TAPE);
   endfunction : is_auto

   // ----------------------------------------
   // Edge detection on filtered pins and the command strobe
   // ----------------------------------------
   ncos_pin_t prev_q;            // Filtered pins one cycle back
   logic      diag_rise;         // Diagnosis just passed
   logic      arst_rise;         // Alarm reset just seen
   logic      estop_fall;        // Emergency stop released
   logic      bstop_rise;        // Block stop event
   logic      fdone_rise;        // Feed completion event
   logic      strobe_rise;       // Strobe rising edge

   assign diag_rise   = pin_f.servo_diag_ok & ~prev_q.servo_diag_ok;
   assign arst_rise   = pin_f.servo_alarm_reset & ~prev_q.servo_alarm_reset;
   assign estop_fall  = ~pin_f.estop & prev_q.estop;
   assign bstop_rise  = pin_f.block_stop & ~prev_q.block_stop;
   assign fdone_rise  = pin_f.feed_done & ~prev_q.feed_done;
   assign strobe_rise = strobe & ~strobe_prev_q;

   // Previous values for edge detectors
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         prev_q        <= '0;
         strobe_prev_q <= 1'b0;
      end
      else
      begin
         prev_q        <= pin_f;
         strobe_prev_q <= strobe;
      end
   end

   // ----------------------------------------
   // Reset condition and hold timer
   // ----------------------------------------
   logic             reset_cond;    // Rewind, stop or alarm
   logic             stop_alarm;    // Stop or alarm present
   logic [CNT_W-1:0] hold_q;        // Remaining hold cycles
   logic [CNT_W-1:0] hold_d;
   logic [CNT_W-1:0] hold_load;     // Hold figure for current cause
   logic             hold_zero;     // Timer expired
   logic             boot_q;        // Power-up hold has run out once
   logic             boot_d;

   assign stop_alarm = pin_f.estop | pin_f.servo_alarm;
   assign reset_cond = reset_rewind_cmd | stop_alarm;
   assign hold_zero  = (hold_q == '0);

   // Stop/alarm figure wins when both causes overlap; a longer remaining count is kept
   assign hold_load = stop_alarm ? CNT_W'(STOP_CYC_P) : CNT_W'(RRW_CYC_P);
   assign hold_d    = reset_cond ? ((hold_load > hold_q) ? hold_load : hold_q) :
                      (hold_zero ? hold_q : hold_q - CNT_W'(1));
   assign boot_d    = boot_q | (hold_zero & ~reset_cond);

   // Timer loads the power-up figure at reset
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         hold_q <= CNT_W'(PWRUP_CYC_P);
         boot_q <= 1'b0;
      end
      else
      begin
         hold_q <= hold_d;
         boot_q <= boot_d;
      end
   end

   // ----------------------------------------
   // Mode switching
   // ----------------------------------------
   logic [2:0] mode_q;           // Active mode
   logic [2:0] mode_d;
   logic       smooth_zero;      // No command axis delayed

   // Auxiliary axes never hold off a mode change
   assign smooth_zero = ~|(pin_f.axis_accdec_busy & ~pin_f.axis_is_plc);

   // A new mode only lands once motion has settled
   assign mode_d = smooth_zero ? mode_req : mode_q;

   // Active mode register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode_q <= MODE_MEM;
      end
      else
      begin
         mode_q <= mode_d;
      end
   end

   // ----------------------------------------
   // Readiness
   // ----------------------------------------
   logic fatal_q;                // Sticky fatal alarm, cleared by power only
   logic fatal_d;
   logic ctrl_clear;             // Controller ready must drop
   logic sv_clear;               // Servo ready must drop
   logic sv_set;                 // Servo ready may rise
   logic ctrl_ready_d;
   logic servo_ready_d;
   ncos_flags_t flags_q;         // Registered flags, also read by the hold terms
   ncos_flags_t flags_d;

   assign fatal_d      = fatal_q | pin_f.servo_alarm_fatal;
   assign ctrl_clear   = pin_f.power_fail | pin_f.cpu_fault | fatal_d;
   assign ctrl_ready_d = boot_d & ~ctrl_clear;

   // Servo-off requests are not part of the clear term
   assign sv_clear = pin_f.servo_alarm | pin_f.estop | ctrl_clear;
   assign sv_set   = diag_rise | arst_rise | estop_fall;
   assign servo_ready_d = ~sv_clear & (flags_q.servo_ready | sv_set);

   // Fatal alarm latch
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         fatal_q <= 1'b0;
      end
      else
      begin
         fatal_q <= fatal_d;
      end
   end

   // ----------------------------------------
   // Automatic operation state
   // ----------------------------------------
   ncos_auto_t auto_q;           // Current state
   ncos_auto_t auto_d;
   logic       go;               // Start may launch or resume
   logic       halt;             // Pause or switch to manual

   // Resume needs pause released and an automatic mode
   assign go   = start_q & pause_n & is_auto(mode_q);
   // Level pause, so lock or M-function cannot mask it
   assign halt = ~pause_n | ~is_auto(mode_q);

   // Next-state selection, reset condition first
   always_comb
   begin
      auto_d = auto_q;
      if (reset_cond)
      begin
         auto_d = ST_RESET;
      end
      else
      begin
         case (auto_q)
            ST_RESET:
            begin
               if (go)
               begin
                  auto_d = ST_EXEC;
               end
            end
            ST_EXEC:
            begin
               if (halt)
               begin
                  auto_d = ST_PAUSED;
               end
               else if (bstop_rise)
               begin
                  auto_d = ST_STOPPED;
               end
            end
            ST_STOPPED:
            begin
               // Pause during a block stop still counts as a pause
               if (halt)
               begin
                  auto_d = ST_PAUSED;
               end
               else if (go)
               begin
                  auto_d = ST_EXEC;
               end
            end
            ST_PAUSED:
            begin
               if (go)
               begin
                  auto_d = ST_EXEC;
               end
            end
            default:
            begin
               auto_d = ST_RESET;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         auto_q <= ST_RESET;
      end
      else
      begin
         auto_q <= auto_d;
      end
   end

   // ----------------------------------------
   // Manual random feed
   // ----------------------------------------
   logic mrf_set;                // Strobe seen in feed mode
   logic mrf_clr;                // Feed done or rewind
   logic mrf_d;

   assign mrf_set = strobe_rise & (mode_q == MODE_MRF);
   assign mrf_clr = fdone_rise | reset_rewind_cmd;
   // A new strobe in the clearing cycle is kept
   assign mrf_d   = mrf_set | (flags_q.manual_random_feed_active & ~mrf_clr);

   // ----------------------------------------
   // Flag outputs
   // ----------------------------------------
   // Flags are decoded from the next state so they land with it
   always_comb
   begin
      flags_d                           = '0;
      flags_d.controller_ready          = ctrl_ready_d;
      flags_d.servo_ready               = servo_ready_d;
      flags_d.auto_run_flag             = (auto_d != ST_RESET);
      flags_d.auto_executing_flag       = (auto_d == ST_EXEC);
      flags_d.auto_paused_flag          = (auto_d == ST_PAUSED);
      flags_d.in_reset_flag             = reset_cond | ~(hold_d == '0);
      flags_d.manual_random_feed_active = mrf_d;
      flags_d.mdi_mode_flag             = (mode_d == MODE_MDI);
      flags_d.all_axes_smoothing_zero   = smooth_zero;
   end

   // All flags clear at reset
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         flags_q <= '0;
      end
      else
      begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;

   // ----------------------------------------
   // Status word
   // ----------------------------------------
   // Servo-off bits are only read back, never acted on
   always_comb
   begin
      status_word                      = 32'h00000000;
      status_word[$bits(ncos_flags_t)-1:0] = flags_q;
      status_word[ST_MODE +: 3]        = mode_q;
      status_word[ST_SVOFF +: NAXES]   = pin_f.axis_servo_off_n;
   end

endmodule : ncos_status

// *** tb/ncos_status_props.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Status flag checker
// ----------------------------------------
module ncos_status_props
   import ncos_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire ncos_pin_t   pins,
   input wire ncos_flags_t flags
);
   logic fault_any;   // Any pin that may drop servo ready
   assign fault_any = pins.estop | pins.servo_alarm | pins.cpu_fault | pins.power_fail | pins.servo_alarm_fatal;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Eight held cycles cover the pin synchroniser plus the flag register
   a_triple_legal: assert property ((flags.auto_executing_flag || flags.auto_paused_flag) |->
      flags.auto_run_flag && !(flags.auto_executing_flag && flags.auto_paused_flag)) else $error("bad auto triple");
   a_stop_run: assert property (pins.estop [*8] |-> !flags.auto_run_flag)
      else $error("run kept under stop");
   a_stop_inreset: assert property (pins.estop [*8] |-> flags.in_reset_flag)
      else $error("in reset missing");
   a_stop_servo: assert property (pins.estop [*8] |-> !flags.servo_ready)
      else $error("servo ready kept");
   a_fault_ready: assert property (pins.cpu_fault [*8] |-> !flags.controller_ready)
      else $error("controller ready kept");
   a_block_exec: assert property ($rose(pins.block_stop) ##1 pins.block_stop [*7] |-> !flags.auto_executing_flag)
      else $error("exec kept at block stop");
   a_feed_clear: assert property ($rose(pins.feed_done) ##1 pins.feed_done [*5] |-> !flags.manual_random_feed_active)
      else $error("feed flag kept");
   a_svoff_keep: assert property ((!fault_any) [*8] ##0 flags.servo_ready |=> flags.servo_ready)
      else $error("servo ready dropped");
endmodule : ncos_status_props
bind ncos_status ncos_status_props u_props (.clk(clk), .rst(rst), .pins(pins), .flags(flags));

// *** tb/ncos_feed_partner.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Machine side: random feed motion
// ----------------------------------------
module ncos_feed_partner
   import ncos_pkg::*;
#(
   parameter int unsigned DELAY = 30   // Travel time in cycles
)(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic active,
   output logic      feed_done
);
   logic [7:0] cnt_q;   // Cycles of travel so far
   // Travel runs only while a feed is commanded
   always_ff @(posedge clk)
   begin
      if (rst || !active)
         cnt_q <= 8'h00;
      else if (cnt_q != DELAY[7:0])
         cnt_q <= cnt_q + 8'h01;
   end
   // Held until the flag drops, so only one rise is seen per feed
   assign feed_done = (cnt_q == DELAY[7:0]);
endmodule : ncos_feed_partner

// *** tb/tb.sv ***
`timescale 1ns/100ps
module tb
   import ncos_pkg::*;
;
   logic        clk;
   logic        rst;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   ncos_pin_t   pin_q;          // Pin levels from the bench
   ncos_pin_t   pins_w;         // Pins with partner completion merged
   ncos_flags_t flags;
   logic        done_w;
   logic [63:0] exp_q[$];       // Mask and expected read data
   logic [31:0] rnd;
   logic [3:0]  sv;
   int          fails;
   int          total_checks;
   // ----------------------------------------
   // Design and partner
   // ----------------------------------------
   always_comb
   begin
      pins_w           = pin_q;
      pins_w.feed_done = done_w;
   end
   ncos_status #(.PWRUP_CYC_P(200), .RRW_CYC_P(20), .STOP_CYC_P(40)) uut (.clk(clk), .rst(rst), .pins(pins_w),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flags(flags));
   ncos_feed_partner #(.DELAY(30)) u_feed (.clk(clk), .rst(rst), .active(flags.manual_random_feed_active),
      .feed_done(done_w));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One Avalon transfer; held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back({m, e});
      bus(1'b0, a, 32'h0);
   endtask : rd
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   // Each completed read is compared with the oldest note
   always @(posedge clk)
   begin
      logic [63:0] n;
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      begin
         n = exp_q.pop_front();
         check(avs_readdata & n[63:32], n[31:0]);
      end
   end
   // ----------------------------------------
   // Clock, watchdog, sequence
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Whole run is under a thousand cycles; a hang is cut well past that
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      conclude();
   end
   initial
   begin
      rst           = 1'b1;
      avs_address   = 4'h0;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0;
      pin_q         = '0;
      rnd           = 32'h0000C1BA;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(4'h0, 32'h20, 32'h3F);
      repeat (230) @(posedge clk);
      rnd = xs(rnd);
      sv  = rnd[3:0];
      rd(4'h0, 32'h01, 32'h21);
      pin_q.axis_servo_off_n <= sv;
      pin_q.servo_diag_ok    <= 1'b1;
      repeat (8) @(posedge clk);
      rd(4'h0, {12'h0, sv, 16'h0002}, 32'h000F0002);
      // Servo-off requests change while servo ready stands
      pin_q.axis_servo_off_n <= ~sv;
      rd(4'h8, 32'h0, 32'hFFFFFFFF);
      repeat (8) @(posedge clk);
      rd(4'h0, {12'h0, ~sv, 16'h0002}, 32'h000F0002);
      // Start, pause, refused restart and rewind in each automatic mode
      for (int m = 0; m < 3; m++)
      begin
         bus(1'b1, 4'h4, {25'h0, m[2:0], 4'h3});
         repeat (3) @(posedge clk);
         rd(4'h0, {17'h0, m[2:0], 4'h0, m == 1, 7'h0C}, 32'h709C);
         bus(1'b1, 4'h4, {25'h0, m[2:0], 4'h0});
         repeat (3) @(posedge clk);
         rd(4'h0, 32'h14, 32'h1C);
         bus(1'b1, 4'h4, {25'h0, m[2:0], 4'h1});
         repeat (3) @(posedge clk);
         rd(4'h0, 32'h14, 32'h1C);
         bus(1'b1, 4'h4, {25'h0, m[2:0], 4'h6});
         repeat (3) @(posedge clk);
         rd(4'h0, 32'h20, 32'h3C);
         bus(1'b1, 4'h4, {25'h0, m[2:0], 4'h2});
         repeat (5) @(posedge clk);
         rd(4'h0, 32'h20, 32'h20);
         repeat (30) @(posedge clk);
         rd(4'h0, 32'h00, 32'h20);
      end
      bus(1'b1, 4'h4, 32'h3);
      repeat (3) @(posedge clk);
      pin_q.block_stop <= 1'b1;
      repeat (8) @(posedge clk);
      rd(4'h0, 32'h04, 32'h1C);
      pin_q.axis_is_plc      <= 4'h1;
      pin_q.axis_accdec_busy <= 4'h1;
      bus(1'b1, 4'h4, 32'h32);
      repeat (8) @(posedge clk);
      rd(4'h0, 32'h3114, 32'h711C);
      pin_q.block_stop <= 1'b0;
      pin_q.estop      <= 1'b1;
      repeat (8) @(posedge clk);
      rd(4'h0, 32'h20, 32'h3E);
      pin_q.estop <= 1'b0;
      repeat (8) @(posedge clk);
      rd(4'h0, 32'h22, 32'h22);
      bus(1'b1, 4'h4, 32'h72);
      repeat (3) @(posedge clk);
      bus(1'b1, 4'h4, 32'h7A);
      repeat (3) @(posedge clk);
      rd(4'h0, 32'h40, 32'h40);
      repeat (40) @(posedge clk);
      rd(4'h0, 32'h00, 32'h40);
      // A delayed command axis holds off the switch to MDI
      pin_q.axis_accdec_busy <= 4'h3;
      repeat (8) @(posedge clk);
      bus(1'b1, 4'h4, 32'h12);
      repeat (3) @(posedge clk);
      rd(4'h0, 32'h7000, 32'h7180);
      pin_q.axis_accdec_busy <= 4'h1;
      repeat (8) @(posedge clk);
      rd(4'h0, 32'h1180, 32'h7180);
      // Resettable servo alarm, then its reset
      pin_q.servo_alarm <= 1'b1;
      repeat (8) @(posedge clk);
      rd(4'h0, 32'h20, 32'h26);
      pin_q.servo_alarm       <= 1'b0;
      pin_q.servo_alarm_reset <= 1'b1;
      repeat (8) @(posedge clk);
      rd(4'h0, 32'h02, 32'h02);
      pin_q.cpu_fault <= 1'b1;
      repeat (8) @(posedge clk);
      rd(4'h0, 32'h00, 32'h03);
      conclude();
   end
endmodule : tb
